// ---- src/t2crb_pkg.sv ----
// Package with register map, field layout and timing counts of the timer.
// Summary of operation
// - Rollover from all-ones sets sticky overflow flag.
// - Rollover sets overflow only with baud selects clear.
// - Software writing overflow flag raises enabled interrupt.
// - Enabled edge pin falling edge sets sticky flag.
// - Software setting edge flag raises enabled interrupt.
// - Receive baud select picks receive timebase.
// - Transmit baud select picks transmit timebase.
// - Any baud select forces divide-by-two baud mode.
// - Outside baud mode, edge acts only when enabled.
// - Run bit counts when set, holds when clear except for edge reload.
// - Source select picks internal ticks or count pin.
// - Baud mode advances every two clocks regardless.
// - Baud mode ignores capture select, reloads on overflow.
// - Reload mode reloads on overflow and enabled edge.
// - Capture mode captures counter on enabled edge.
// - Capture low byte takes counter low, supplies reload.
// - Capture high byte takes counter high, supplies reload.
// - Counter bytes are software visible, reset zero.
package t2crb_pkg;

  // --------------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // --------------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL   = 8'hc8;
  localparam logic [7:0] IDX_CAP_LO = 8'hca;
  localparam logic [7:0] IDX_CAP_HI = 8'hcb;
  localparam logic [7:0] IDX_CNT_LO = 8'hcc;
  localparam logic [7:0] IDX_CNT_HI = 8'hcd;
  localparam logic [7:0] IDX_AUX    = 8'hce;

  // --------------------------------------------------------------------
  // Field layouts.
  // --------------------------------------------------------------------
  typedef struct packed {
    logic overflow_flag;
    logic external_edge_flag;
    logic rx_baud_select;
    logic tx_baud_select;
    logic external_edge_enable;
    logic run_control;
    logic count_source_select;
    logic capture_reload_select;
  } t2crb_ctrl_t;

  typedef struct packed {
    logic [5:0] unused;
    logic       irq_enable;
    logic       timer_speed_select;
  } t2crb_aux_t;

  // --------------------------------------------------------------------
  // Reset values and counter maximum.
  // --------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  CAP_RST  = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [7:0]  AUX_RST  = 8'h00;
  localparam logic [15:0] CNT_MAX  = 16'hffff;

  // --------------------------------------------------------------------
  // Clocks per tick and serial modes.
  // --------------------------------------------------------------------
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_BAUD = 4'h2;
  localparam logic [1:0] SER_MODE1 = 2'h1;
  localparam logic [1:0] SER_MODE3 = 2'h3;

endpackage

// ---- src/t2crb_timer.sv ----
// Timer with capture, auto-reload and baud generation, Avalon-MM slave.
`timescale 1ns/1ps
module t2crb_timer
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pins
  input  wire logic        count_input_pin,
  input  wire logic        edge_input_pin,
  // Serial port zero timebase
  input  wire logic [1:0]  serial_mode,
  input  wire logic        timer1_overflow,
  output logic             rx_baud_tick,
  output logic             tx_baud_tick,
  // Events
  output logic             timer_irq,
  output logic             overflow_pulse
);

  // --------------------------------------------------------------------
  // Register decode.
  // --------------------------------------------------------------------
  function automatic logic reg_hit(input logic [9:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[9:2] == idx);
  endfunction

  t2crb_pkg::t2crb_ctrl_t ctrl_reg;
  t2crb_pkg::t2crb_aux_t  aux_reg;
  logic [7:0]             cap_lo_reg;
  logic [7:0]             cap_hi_reg;
  logic [15:0]            count_reg;
  logic [3:0]             pre_reg;
  logic [2:0]             cnt_pin_sync_reg;
  logic [2:0]             edge_pin_sync_reg;
  logic                   ack_reg;
  logic [31:0]            rdata_reg;
  logic                   rx_tick_reg;
  logic                   tx_tick_reg;
  logic                   ovf_pulse_reg;

  logic                   wr_en;
  logic                   ctrl_wr;
  logic                   cap_lo_wr;
  logic                   cap_hi_wr;
  logic                   cnt_lo_wr;
  logic                   cnt_hi_wr;
  logic                   aux_wr;
  logic [7:0]             wdata;
  logic [7:0]             rd_mux;
  logic                   baud_mode;
  logic                   cnt_fall;
  logic                   edge_fall;
  logic [3:0]             div_sel;
  logic                   pre_end;
  logic                   tick;
  logic                   ovf_evt;
  logic                   ext_evt;
  logic                   ext_act;
  logic                   reload;
  logic                   capture;
  logic                   async_mode;

  // --------------------------------------------------------------------
  // Bus handshake: one wait cycle, then the answer.
  // --------------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_en = avs_write & ack_reg & avs_byteenable[0];
  assign wdata = avs_writedata[7:0];
  assign ctrl_wr   = wr_en & reg_hit(avs_address, t2crb_pkg::IDX_CTRL);
  assign cap_lo_wr = wr_en & reg_hit(avs_address, t2crb_pkg::IDX_CAP_LO);
  assign cap_hi_wr = wr_en & reg_hit(avs_address, t2crb_pkg::IDX_CAP_HI);
  assign cnt_lo_wr = wr_en & reg_hit(avs_address, t2crb_pkg::IDX_CNT_LO);
  assign cnt_hi_wr = wr_en & reg_hit(avs_address, t2crb_pkg::IDX_CNT_HI);
  assign aux_wr    = wr_en & reg_hit(avs_address, t2crb_pkg::IDX_AUX);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  always_comb
  begin
    rd_mux = 8'h00;
    if (reg_hit(avs_address, t2crb_pkg::IDX_CTRL))
      rd_mux = ctrl_reg;
    else if (reg_hit(avs_address, t2crb_pkg::IDX_CAP_LO))
      rd_mux = cap_lo_reg;
    else if (reg_hit(avs_address, t2crb_pkg::IDX_CAP_HI))
      rd_mux = cap_hi_reg;
    else if (reg_hit(avs_address, t2crb_pkg::IDX_CNT_LO))
      rd_mux = count_reg[7:0];
    else if (reg_hit(avs_address, t2crb_pkg::IDX_CNT_HI))
      rd_mux = count_reg[15:8];
    else if (reg_hit(avs_address, t2crb_pkg::IDX_AUX))
      rd_mux = aux_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read & ~ack_reg)
      rdata_reg <= {24'h00_0000, rd_mux};
  end

  assign avs_readdata = rdata_reg;

  // --------------------------------------------------------------------
  // Pin synchronisers and falling edge detect.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_pin_sync_reg  <= 3'h0;
      edge_pin_sync_reg <= 3'h0;
    end
    else
    begin
      cnt_pin_sync_reg  <= {cnt_pin_sync_reg[1:0], count_input_pin};
      edge_pin_sync_reg <= {edge_pin_sync_reg[1:0], edge_input_pin};
    end
  end

  assign cnt_fall  = cnt_pin_sync_reg[2] & ~cnt_pin_sync_reg[1];
  assign edge_fall = edge_pin_sync_reg[2] & ~edge_pin_sync_reg[1];

  // --------------------------------------------------------------------
  // Tick generation.
  // --------------------------------------------------------------------
  assign baud_mode = ctrl_reg.rx_baud_select | ctrl_reg.tx_baud_select;

  always_comb
  begin
    if (baud_mode)
      div_sel = t2crb_pkg::DIV_BAUD;
    else if (aux_reg.timer_speed_select)
      div_sel = t2crb_pkg::DIV_FAST;
    else
      div_sel = t2crb_pkg::DIV_SLOW;
  end

  assign pre_end = (pre_reg >= div_sel - 4'h1);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pre_reg <= 4'h0;
    else if (!ctrl_reg.run_control || pre_end)
      pre_reg <= 4'h0;
    else
      pre_reg <= pre_reg + 4'h1;
  end

  always_comb
  begin
    if (!ctrl_reg.run_control)
      tick = 1'b0;
    else if (baud_mode || !ctrl_reg.count_source_select)
      tick = pre_end;
    else
      tick = cnt_fall;
  end

  // --------------------------------------------------------------------
  // Overflow, capture and reload decisions.
  // --------------------------------------------------------------------
  assign ovf_evt = tick & (count_reg == t2crb_pkg::CNT_MAX);
  assign ext_evt = edge_fall & ctrl_reg.external_edge_enable;
  assign ext_act = ext_evt & ~baud_mode;
  assign reload  = (ovf_evt & (baud_mode | ~ctrl_reg.capture_reload_select))
                 | (ext_act & ~ctrl_reg.capture_reload_select);
  assign capture = ext_act & ctrl_reg.capture_reload_select;

  // --------------------------------------------------------------------
  // Control register with hardware-set flags.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ctrl_reg <= t2crb_pkg::CTRL_RST;
    else
    begin
      if (ctrl_wr)
        ctrl_reg <= wdata;
      if (ovf_evt && !baud_mode)
        ctrl_reg.overflow_flag <= 1'b1;
      if (ext_evt)
        ctrl_reg.external_edge_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      aux_reg <= t2crb_pkg::AUX_RST;
    else if (aux_wr)
      aux_reg <= {6'h00, wdata[1:0]};
  end

  // --------------------------------------------------------------------
  // Capture and reload value registers.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cap_lo_reg <= t2crb_pkg::CAP_RST;
    else if (cap_lo_wr)
      cap_lo_reg <= wdata;
    else if (capture)
      cap_lo_reg <= count_reg[7:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cap_hi_reg <= t2crb_pkg::CAP_RST;
    else if (cap_hi_wr)
      cap_hi_reg <= wdata;
    else if (capture)
      cap_hi_reg <= count_reg[15:8];
  end

  // --------------------------------------------------------------------
  // Counter.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      count_reg <= t2crb_pkg::CNT_RST;
    else if (cnt_lo_wr)
      count_reg[7:0] <= wdata;
    else if (cnt_hi_wr)
      count_reg[15:8] <= wdata;
    else if (reload)
      count_reg <= {cap_hi_reg, cap_lo_reg};
    else if (tick)
      count_reg <= count_reg + 16'h0001;
  end

  // --------------------------------------------------------------------
  // Serial timebase selection and event outputs.
  // --------------------------------------------------------------------
  assign async_mode = (serial_mode == t2crb_pkg::SER_MODE1)
                    | (serial_mode == t2crb_pkg::SER_MODE3);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rx_tick_reg   <= 1'b0;
      tx_tick_reg   <= 1'b0;
      ovf_pulse_reg <= 1'b0;
    end
    else
    begin
      rx_tick_reg <= (ctrl_reg.rx_baud_select & async_mode)
                   ? ovf_evt : timer1_overflow;
      tx_tick_reg <= (ctrl_reg.tx_baud_select & async_mode)
                   ? ovf_evt : timer1_overflow;
      ovf_pulse_reg <= ovf_evt;
    end
  end

  assign rx_baud_tick   = rx_tick_reg;
  assign tx_baud_tick   = tx_tick_reg;
  assign overflow_pulse = ovf_pulse_reg;
  assign timer_irq = aux_reg.irq_enable
                   & (ctrl_reg.overflow_flag
                   | ctrl_reg.external_edge_flag);

  // --------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_ovf_set;
    ovf_evt && !baud_mode |=> ctrl_reg.overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("Overflow flag not set on rollover.");

  property p_no_ovf_baud;
    baud_mode && !ctrl_reg.overflow_flag && !ctrl_wr
      |=> !ctrl_reg.overflow_flag;
  endproperty
  a_no_ovf_baud: assert property (p_no_ovf_baud)
    else $error("Overflow flag set in baud mode.");

  property p_sw_irq;
    ctrl_wr && wdata[7] && aux_reg.irq_enable && !aux_wr |=> timer_irq;
  endproperty
  a_sw_irq: assert property (p_sw_irq)
    else $error("Software overflow flag gave no interrupt.");

  property p_ext_set;
    ext_evt |=> ctrl_reg.external_edge_flag ##1
      (ctrl_reg.external_edge_flag || $past(ctrl_wr));
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("Edge flag not set or not held.");

  property p_halt;
    !ctrl_reg.run_control && !reload && !cnt_lo_wr && !cnt_hi_wr
      |=> $stable(count_reg);
  endproperty
  a_halt: assert property (p_halt)
    else $error("Counter moved while halted.");

  property p_baud_rate;
    baud_mode && ctrl_reg.run_control && tick
      |=> !tick ##1 (tick || !baud_mode || !ctrl_reg.run_control);
  endproperty
  a_baud_rate: assert property (p_baud_rate)
    else $error("Baud mode tick not every two clocks.");

  property p_baud_reload;
    baud_mode && ovf_evt && !cnt_lo_wr && !cnt_hi_wr
      |=> count_reg == {$past(cap_hi_reg), $past(cap_lo_reg)};
  endproperty
  a_baud_reload: assert property (p_baud_reload)
    else $error("No reload after baud overflow.");

  property p_edge_reload;
    ext_evt && !baud_mode && !ctrl_reg.capture_reload_select
      && !cnt_lo_wr && !cnt_hi_wr
      |=> count_reg == {$past(cap_hi_reg), $past(cap_lo_reg)};
  endproperty
  a_edge_reload: assert property (p_edge_reload)
    else $error("No reload on enabled edge.");

  property p_capture;
    ext_evt && !baud_mode && ctrl_reg.capture_reload_select
      && !cap_lo_wr && !cap_hi_wr
      |=> {cap_hi_reg, cap_lo_reg} == $past(count_reg);
  endproperty
  a_capture: assert property (p_capture)
    else $error("Capture did not take the counter.");

  property p_edge_ignored;
    edge_fall && !ctrl_reg.external_edge_enable
      && !ctrl_reg.external_edge_flag && !ctrl_wr
      |=> !ctrl_reg.external_edge_flag;
  endproperty
  a_edge_ignored: assert property (p_edge_ignored)
    else $error("Edge acted while disabled.");

  property p_rx_src;
    ctrl_reg.rx_baud_select && async_mode
      |=> rx_baud_tick == $past(ovf_evt);
  endproperty
  a_rx_src: assert property (p_rx_src)
    else $error("Receive timebase not taken from this timer.");

  property p_tx_src;
    ctrl_reg.tx_baud_select && async_mode
      |=> tx_baud_tick == $past(ovf_evt);
  endproperty
  a_tx_src: assert property (p_tx_src)
    else $error("Transmit timebase not taken from this timer.");

  c_capture: cover property (capture);
  c_baud_ovf: cover property (baud_mode && ovf_evt);
  c_edge_reload: cover property (ext_act && reload);
  c_irq: cover property (!timer_irq ##1 timer_irq);

endmodule // t2crb_timer

// ---- bench/t2crb_pin_model.sv ----
// Model of the far side driving the count and edge input pins.
`timescale 1ns/1ps
module t2crb_pin_model
(
  // Clock
  input  wire logic clk_sys,
  // Pins
  output logic      count_input_pin,
  output logic      edge_input_pin
);

  // ------------------------------------------------------------------
  // Pins idle high, as on a pulled-up line.
  // ------------------------------------------------------------------
  initial
  begin
    count_input_pin = 1'b1;
    edge_input_pin  = 1'b1;
  end

  // Each level is held three clocks so the synchroniser sees it.
  task automatic fall(input bit on_edge, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      if (on_edge)
        edge_input_pin <= 1'b0;
      else
        count_input_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      edge_input_pin  <= 1'b1;
      count_input_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
  endtask

endmodule // t2crb_pin_model

// ---- bench/test_timer2_capture_reload_baud.sv ----
// Self-checking testbench of the capture, reload and baud timer.
`timescale 1ns/1ps
module test_timer2_capture_reload_baud;

  logic        clk_sys;
  logic        sys_rst;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        count_input_pin;
  logic        edge_input_pin;
  logic [1:0]  serial_mode;
  logic        timer1_overflow;
  logic        rx_baud_tick;
  logic        tx_baud_tick;
  logic        timer_irq;
  logic        overflow_pulse;
  int          mismatches;
  int          cmp_count;

  t2crb_timer t2crb_timer_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .count_input_pin(count_input_pin), .edge_input_pin(edge_input_pin),
    .serial_mode(serial_mode), .timer1_overflow(timer1_overflow),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
    .timer_irq(timer_irq), .overflow_pulse(overflow_pulse));

  t2crb_pin_model t2crb_pin_model_i (.clk_sys(clk_sys),
    .count_input_pin(count_input_pin), .edge_input_pin(edge_input_pin));

  // ------------------------------------------------------------------
  // Bus cycles and comparison.
  // ------------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    avs_address   <= {idx, 2'b00};
    avs_read      <= ~w;
    avs_write     <= w;
    avs_writedata <= {24'h00_0000, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rdc(input string n, input logic [7:0] idx,
                     input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(n, {8'h00, q}, {8'h00, e});
  endtask

  task automatic period(input bit rx, output int n);
    while ((rx ? rx_baud_tick : tx_baud_tick) !== 1'b1) @(posedge clk_sys);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while ((rx ? rx_baud_tick : tx_baud_tick) !== 1'b1);
  endtask

  // ------------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------------
  task automatic t_reset;
    rdc("ctrl", t2crb_pkg::IDX_CTRL, t2crb_pkg::CTRL_RST);
    rdc("cap lo", t2crb_pkg::IDX_CAP_LO, t2crb_pkg::CAP_RST);
    rdc("cap hi", t2crb_pkg::IDX_CAP_HI, t2crb_pkg::CAP_RST);
    rdc("cnt lo", t2crb_pkg::IDX_CNT_LO, 8'h00);
    rdc("cnt hi", t2crb_pkg::IDX_CNT_HI, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    wr(t2crb_pkg::IDX_CAP_LO, 8'h5a);
    wr(t2crb_pkg::IDX_CAP_HI, 8'ha5);
    rdc("cap lo rw", t2crb_pkg::IDX_CAP_LO, 8'h5a);
    rdc("cap hi rw", t2crb_pkg::IDX_CAP_HI, 8'ha5);
  endtask

  task automatic t_overflow;
    logic [7:0] lo;
    int n;
    wr(t2crb_pkg::IDX_CAP_LO, 8'hf0);
    wr(t2crb_pkg::IDX_CAP_HI, 8'hff);
    wr(t2crb_pkg::IDX_CNT_LO, 8'hfe);
    wr(t2crb_pkg::IDX_CNT_HI, 8'hff);
    wr(t2crb_pkg::IDX_AUX, 8'h01);
    wr(t2crb_pkg::IDX_CTRL, 8'h04);
    while (overflow_pulse !== 1'b1) @(posedge clk_sys);
    rdc("ovf flag", t2crb_pkg::IDX_CTRL, 8'h84);
    wr(t2crb_pkg::IDX_CTRL, 8'h80);
    bus(1'b0, t2crb_pkg::IDX_CNT_LO, 8'h00, lo);
    rdc("reload hi", t2crb_pkg::IDX_CNT_HI, 8'hff);
    rdc("halted lo", t2crb_pkg::IDX_CNT_LO, lo);
    wr(t2crb_pkg::IDX_AUX, 8'h03);
    rdc("sticky", t2crb_pkg::IDX_CTRL, 8'h80);
    chk("irq ovf", {15'h0000, timer_irq}, 16'h0001);
    wr(t2crb_pkg::IDX_CTRL, 8'h00);
    rdc("clear", t2crb_pkg::IDX_CTRL, 8'h00);
    chk("irq clr", {15'h0000, timer_irq}, 16'h0000);
    wr(t2crb_pkg::IDX_CTRL, 8'h40);
    rdc("sw edge", t2crb_pkg::IDX_CTRL, 8'h40);
    chk("irq sw", {15'h0000, timer_irq}, 16'h0001);
    wr(t2crb_pkg::IDX_AUX, 8'h01);
    rdc("mask", t2crb_pkg::IDX_CTRL, 8'h40);
    chk("irq mask", {15'h0000, timer_irq}, 16'h0000);
    wr(t2crb_pkg::IDX_AUX, 8'h00);
    wr(t2crb_pkg::IDX_CTRL, 8'h04);
    while (overflow_pulse !== 1'b1) @(posedge clk_sys);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (overflow_pulse !== 1'b1);
    chk("slow period", 16'(n), 16'h00c0);
  endtask

  task automatic t_capture;
    wr(t2crb_pkg::IDX_CTRL, 8'h00);
    wr(t2crb_pkg::IDX_CNT_HI, 8'h12);
    wr(t2crb_pkg::IDX_CNT_LO, 8'h34);
    wr(t2crb_pkg::IDX_CAP_LO, 8'h5a);
    wr(t2crb_pkg::IDX_CTRL, 8'h07);
    t2crb_pin_model_i.fall(1'b0, 3);
    t2crb_pin_model_i.fall(1'b1, 1);
    rdc("pin count", t2crb_pkg::IDX_CNT_LO, 8'h37);
    rdc("no capture", t2crb_pkg::IDX_CAP_LO, 8'h5a);
    rdc("no flag", t2crb_pkg::IDX_CTRL, 8'h07);
    wr(t2crb_pkg::IDX_CTRL, 8'h0f);
    t2crb_pin_model_i.fall(1'b1, 1);
    rdc("capture lo", t2crb_pkg::IDX_CAP_LO, 8'h37);
    rdc("capture hi", t2crb_pkg::IDX_CAP_HI, 8'h12);
    rdc("edge flag", t2crb_pkg::IDX_CTRL, 8'h4f);
    wr(t2crb_pkg::IDX_CTRL, 8'h08);
    wr(t2crb_pkg::IDX_CAP_LO, 8'hbc);
    wr(t2crb_pkg::IDX_CAP_HI, 8'h0a);
    t2crb_pin_model_i.fall(1'b1, 1);
    rdc("edge rl lo", t2crb_pkg::IDX_CNT_LO, 8'hbc);
    rdc("edge rl hi", t2crb_pkg::IDX_CNT_HI, 8'h0a);
    rdc("edge flag2", t2crb_pkg::IDX_CTRL, 8'h48);
  endtask

  task automatic t_baud;
    int n;
    wr(t2crb_pkg::IDX_CTRL, 8'h00);
    serial_mode <= 2'h1;
    wr(t2crb_pkg::IDX_CAP_LO, 8'hf0);
    wr(t2crb_pkg::IDX_CAP_HI, 8'hff);
    wr(t2crb_pkg::IDX_CNT_LO, 8'hf0);
    wr(t2crb_pkg::IDX_CNT_HI, 8'hff);
    wr(t2crb_pkg::IDX_CTRL, 8'h17);
    period(1'b0, n);
    chk("tx period", 16'(n), 16'h0020);
    rdc("baud no ovf", t2crb_pkg::IDX_CTRL, 8'h17);
    @(posedge clk_sys);
    timer1_overflow <= 1'b1;
    @(posedge clk_sys);
    timer1_overflow <= 1'b0;
    @(posedge clk_sys);
    chk("rx timer1", {15'h0000, rx_baud_tick}, 16'h0001);
    serial_mode <= 2'h3;
    wr(t2crb_pkg::IDX_CTRL, 8'h24);
    period(1'b1, n);
    chk("rx period", 16'(n), 16'h0020);
  endtask

  // ------------------------------------------------------------------
  // Verdict, clock, watchdog and main sequence.
  // ------------------------------------------------------------------
  task automatic end_of_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    mismatches      = 0;
    cmp_count       = 0;
    sys_rst         = 1'b1;
    avs_address     = 10'h000;
    avs_read        = 1'b0;
    avs_write       = 1'b0;
    avs_writedata   = 32'h0000_0000;
    avs_byteenable  = 4'h1;
    serial_mode     = 2'h0;
    timer1_overflow = 1'b0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_overflow();
    t_capture();
    t_baud();
    end_of_test();
  end

endmodule // test_timer2_capture_reload_baud
